//--- hdl/prm_monitor.sv
// Monitor, protection, converter sequencer and pin control for the receiver
`timescale 1ns/10ps
`default_nettype none

module prm_monitor #(
  parameter int LDO_DELAY = prm_pkg::LDO_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [7:0]             regRdata,
  // Analog comparators and supply monitors
  input  wire prm_pkg::prm_sense_type senseIn,
  // Converter front end
  output logic      [2:0]             adcChanSel,
  output logic                        adcSample,
  output logic      [11:0]            adcTrial,
  // Power control
  output logic                        buckEnable,
  output logic                        ldoEnable,
  output logic                        ldoDischarge,
  output logic                        ldoFeedFromBuck,
  // Open-drain pins
  output logic      [3:0]             pinOut,
  output logic      [3:0]             pinOe,
  output logic                        irqOut,
  output logic                        irqOe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  prm_pkg::prm_sense_type senseMeta;
  prm_pkg::prm_sense_type senseSync;
  prm_pkg::prm_sense_type sensePrev;
  prm_pkg::prm_flags_type flags_q;
  prm_pkg::prm_flags_type flags_d;
  prm_pkg::prm_flags_type flagSet;
  prm_pkg::prm_seq_type   seq_q;
  logic [5:0]  flagClr;
  logic        rstAll;
  logic        softRst_q;
  logic [7:0]  irqEn_q;
  logic [7:0]  sysLow_q;
  logic [7:0]  sysHigh_q;
  logic [7:0]  pinCtrl_q;
  logic [7:0]  chanEn_q;
  logic [3:0]  pinLevel_q;
  logic        cutoff;
  logic        wrHit;
  logic        startScan;
  logic [3:0]  firstChan;
  logic [3:0]  nextChan;
  logic [2:0]  chan_q;
  logic [3:0]  bit_q;
  logic [4:0]  cnt_q;
  logic [11:0] trial_q;
  logic [11:0] resultMem [0:prm_pkg::CHANS-1];
  logic [$clog2(LDO_DELAY+1)-1:0] ldoCnt_q;

  // First selected channel at or above a start index
  function automatic logic [3:0] findChan(input logic [6:0] sel, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = prm_pkg::CHANS - 1; i >= 0; i--) begin
      if (sel[i] && (4'(i) >= from)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every pin and comparator level crosses two stages before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      senseMeta <= '0;
      senseSync <= '0;
      sensePrev <= '0;
    end else begin
      senseMeta <= senseIn;
      senseSync <= senseMeta;
      sensePrev <= senseSync;
    end
  end

  // ----------------------------------------------------------------
  // Soft reset
  // ----------------------------------------------------------------
  // Self-clearing; resets register state one cycle after the write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      softRst_q <= 1'b0;
    end else begin
      softRst_q <= regWr && (regAddr == prm_pkg::ADDR_SYS_HIGH)
                   && regWdata[prm_pkg::SOFT_RST_BIT];
    end
  end

  assign rstAll = rst | softRst_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Plain read/write control bytes
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      irqEn_q   <= prm_pkg::RST_IRQ_EN;
      sysLow_q  <= prm_pkg::RST_SYS_LOW;
      pinCtrl_q <= prm_pkg::RST_PIN_CTRL;
    end else if (regWr) begin
      if (regAddr == prm_pkg::ADDR_IRQ_EN) begin
        irqEn_q <= regWdata;
      end
      if (regAddr == prm_pkg::ADDR_SYS_LOW) begin
        sysLow_q <= regWdata;
      end
      if (regAddr == prm_pkg::ADDR_PIN_CTRL) begin
        pinCtrl_q <= regWdata;
      end
    end
  end

  // Protection cutoff; hardware clearing of the run bit beats a host write
  assign cutoff = (sysLow_q[prm_pkg::SYS_TEMP_CUT_BIT] & |(flags_q.hot & irqEn_q[1:0]))
                | (sysLow_q[prm_pkg::SYS_NTC_CUT_BIT] & flags_q.ntcHot);

  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      sysHigh_q <= prm_pkg::RST_SYS_HIGH;
    end else begin
      if (regWr && (regAddr == prm_pkg::ADDR_SYS_HIGH)) begin
        sysHigh_q <= regWdata & ~(8'h01 << prm_pkg::SOFT_RST_BIT);
      end
      if (cutoff) begin
        sysHigh_q[prm_pkg::BUCK_RUN_BIT] <= 1'b0;
      end
    end
  end

  // Channel enable; run bit reads one only while the scan is busy
  assign wrHit     = regWr && (regAddr == prm_pkg::ADDR_CHAN_EN);
  assign startScan = wrHit && regWdata[prm_pkg::CONV_RUN_BIT];

  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      chanEn_q <= prm_pkg::RST_CHAN_EN;
    end else if (wrHit) begin
      chanEn_q <= regWdata;
    end else if (seq_q == prm_pkg::SEQ_IDLE) begin
      chanEn_q[prm_pkg::CONV_RUN_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Rising edges of synchronised levels only, so a held level sets once
  always_comb begin
    flagSet.hot     = senseSync.dieHot  & ~sensePrev.dieHot;
    flagSet.cooled  = senseSync.dieCool & ~sensePrev.dieCool;
    flagSet.ntcHot  = senseSync.ntcHot  & ~sensePrev.ntcHot;
    flagSet.ntcCold = senseSync.ntcCold & ~sensePrev.ntcCold;
    flagClr = 6'h00;
    if (regWr && (regAddr == prm_pkg::ADDR_FLAG_CLR)) begin
      flagClr = regWdata[6:1];
    end
    if (regRd && (regAddr == prm_pkg::ADDR_STATUS_LOW)
        && sysLow_q[prm_pkg::SYS_READ_CLR_BIT]) begin
      flagClr = flagClr | prm_pkg::READ_CLR_MASK;
    end
    // A new edge wins over a clear in the same cycle
    flags_d = (flags_q & ~flagClr) | flagSet;
  end

  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  // Open drain: line pulled low while any qualifying flag stands
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      irqOe <= 1'b0;
    end else begin
      irqOe <= (|flags_q.hot) | (|flags_q.cooled)
             | (flags_q.ntcHot  & irqEn_q[prm_pkg::IE_NTC_HOT_BIT])
             | (flags_q.ntcCold & irqEn_q[prm_pkg::IE_NTC_COLD_BIT]);
    end
  end

  assign irqOut = 1'b0;

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  assign firstChan = findChan(regWdata[6:0], 4'h0);
  assign nextChan  = findChan(chanEn_q[6:0], {1'b0, chan_q} + 4'h1);

  // One pass: sample, twelve trial steps, store, then next channel.
  // Worst case about 800 cycles, far below one serial byte time.
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      seq_q     <= prm_pkg::SEQ_IDLE;
      chan_q    <= 3'h0;
      bit_q     <= 4'h0;
      cnt_q     <= 5'h00;
      trial_q   <= 12'h000;
      adcSample <= 1'b0;
    end else if (startScan) begin
      // A new start restarts the pass from the lowest selected channel
      cnt_q <= 5'h00;
      if (firstChan[3]) begin
        seq_q     <= prm_pkg::SEQ_SAMPLE;
        chan_q    <= firstChan[2:0];
        adcSample <= 1'b1;
      end else begin
        seq_q     <= prm_pkg::SEQ_IDLE;
        adcSample <= 1'b0;
      end
    end else begin
      unique case (seq_q)
        prm_pkg::SEQ_IDLE: begin
          adcSample <= 1'b0;
        end
        prm_pkg::SEQ_SAMPLE: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(prm_pkg::SAMPLE_CYCLES - 1)) begin
            cnt_q     <= 5'h00;
            adcSample <= 1'b0;
            seq_q     <= prm_pkg::SEQ_TRIAL;
            bit_q     <= 4'(prm_pkg::RES_W - 1);
            trial_q   <= 12'h800;
          end
        end
        prm_pkg::SEQ_TRIAL: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(prm_pkg::STEP_CYCLES - 1)) begin
            cnt_q <= 5'h00;
            // Comparator low means the trial code overshoots
            trial_q[bit_q] <= senseSync.adcCmp;
            if (bit_q == 4'h0) begin
              seq_q <= prm_pkg::SEQ_STORE;
            end else begin
              bit_q              <= bit_q - 4'h1;
              trial_q[bit_q - 1] <= 1'b1;
            end
          end
        end
        prm_pkg::SEQ_STORE: begin
          if (nextChan[3]) begin
            seq_q     <= prm_pkg::SEQ_SAMPLE;
            chan_q    <= nextChan[2:0];
            adcSample <= 1'b1;
          end else begin
            seq_q <= prm_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Result store, one word per channel
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      for (int i = 0; i < prm_pkg::CHANS; i++) begin
        resultMem[i] <= 12'h000;
      end
    end else if (seq_q == prm_pkg::SEQ_STORE) begin
      resultMem[chan_q] <= trial_q;
    end
  end

  assign adcChanSel = chan_q;
  assign adcTrial   = trial_q;

  // ----------------------------------------------------------------
  // Supply control
  // ----------------------------------------------------------------
  // Start-up delay counter; brown-out drops the LDO at once, the buck keeps running
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      ldoCnt_q     <= '0;
      ldoEnable    <= 1'b0;
      ldoDischarge <= 1'b1;
    end else if (senseSync.bodLow) begin
      ldoCnt_q     <= '0;
      ldoEnable    <= 1'b0;
      ldoDischarge <= 1'b1;
    end else if (!senseSync.dcInOk) begin
      ldoCnt_q <= '0;
    end else if (!ldoEnable) begin
      ldoCnt_q <= ldoCnt_q + ($bits(ldoCnt_q))'(1);
      if (ldoCnt_q == ($bits(ldoCnt_q))'(LDO_DELAY - 1)) begin
        ldoEnable    <= 1'b1;
        ldoDischarge <= 1'b0;
      end
    end
  end

  // Buck run and LDO feed selection
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      buckEnable      <= 1'b0;
      ldoFeedFromBuck <= 1'b0;
    end else begin
      buckEnable      <= sysHigh_q[prm_pkg::BUCK_RUN_BIT] & ~cutoff;
      ldoFeedFromBuck <= senseSync.buckGood;
    end
  end

  // ----------------------------------------------------------------
  // General pins
  // ----------------------------------------------------------------
  // Gated buffer reads zero; costs one cycle on the drive enable
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      pinLevel_q <= 4'h0;
      pinOe      <= 4'h0;
    end else begin
      pinLevel_q <= senseSync.pinIn & pinCtrl_q[7:4];
      pinOe      <= ~pinCtrl_q[3:0];
    end
  end

  assign pinOut = 4'h0;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stands in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= 8'h00;
      if (regAddr == prm_pkg::ADDR_STATUS_LOW) begin
        regRdata <= {1'b0, flags_q, 1'b0};
      end
      if (regAddr == prm_pkg::ADDR_IRQ_EN) begin
        regRdata <= irqEn_q;
      end
      if (regAddr == prm_pkg::ADDR_SYS_LOW) begin
        regRdata <= sysLow_q;
      end
      if (regAddr == prm_pkg::ADDR_SYS_HIGH) begin
        regRdata <= sysHigh_q;
      end
      if (regAddr == prm_pkg::ADDR_PIN_CTRL) begin
        regRdata <= pinCtrl_q;
      end
      if (regAddr == prm_pkg::ADDR_PIN_LEVEL) begin
        regRdata <= {4'h0, pinLevel_q};
      end
      if (regAddr == prm_pkg::ADDR_CHAN_EN) begin
        regRdata <= chanEn_q;
      end
      for (int i = 0; i < prm_pkg::CHANS; i++) begin
        if (regAddr == prm_pkg::ADDR_RES_HI0 + 8'(i)) begin
          regRdata <= resultMem[i][11:4];
        end
        if (regAddr == prm_pkg::ADDR_RES_LO0 + 8'(i)) begin
          regRdata <= {4'h0, resultMem[i][3:0]};
        end
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

//--- hdl/prm_pkg.sv
// Constants, field layouts and carrier types for the receiver monitor block
package prm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CHANS  = 7;
  localparam int RES_W  = 12;
  localparam int PINS   = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_LOW = 8'h00;
  localparam logic [7:0] ADDR_STATUS_HIGH = 8'h01;
  localparam logic [7:0] ADDR_FLAG_CLR   = 8'h02;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h04;
  localparam logic [7:0] ADDR_SYS_LOW    = 8'h05;
  localparam logic [7:0] ADDR_SYS_HIGH   = 8'h06;
  localparam logic [7:0] ADDR_PIN_CTRL   = 8'h07;
  localparam logic [7:0] ADDR_PIN_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_CHAN_EN    = 8'h09;
  localparam logic [7:0] ADDR_RES_HI0    = 8'h0B;
  localparam logic [7:0] ADDR_RES_LO0    = 8'h12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_EN   = 8'h00;
  localparam logic [7:0] RST_SYS_LOW  = 8'h82;
  localparam logic [7:0] RST_SYS_HIGH = 8'hF4;
  localparam logic [7:0] RST_PIN_CTRL = 8'h0F;
  localparam logic [7:0] RST_CHAN_EN  = 8'h7F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYS_READ_CLR_BIT = 7;
  localparam int SYS_NTC_CUT_BIT  = 3;
  localparam int SYS_TEMP_CUT_BIT = 0;
  localparam int BUCK_RUN_BIT     = 0;
  localparam int SOFT_RST_BIT     = 1;
  localparam int CONV_RUN_BIT     = 7;
  localparam int IE_NTC_HOT_BIT   = 2;
  localparam int IE_NTC_COLD_BIT  = 3;
  localparam logic [5:0] READ_CLR_MASK = 6'h0F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int LDO_DELAY_US    = 1500;
  localparam int LDO_DELAY_CYCLES = LDO_DELAY_US * CLK_MHZ;
  localparam int SAMPLE_CYCLES   = 16;
  localparam int STEP_CYCLES     = 8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       adcCmp;
    logic [1:0] dieHot;
    logic [1:0] dieCool;
    logic       ntcHot;
    logic       ntcCold;
    logic       dcInOk;
    logic       bodLow;
    logic       buckGood;
    logic [3:0] pinIn;
  } prm_sense_type;

  // Same bit order as status bits 6..1
  typedef struct packed {
    logic       ntcCold;
    logic       ntcHot;
    logic [1:0] cooled;
    logic [1:0] hot;
  } prm_flags_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SAMPLE,
    SEQ_TRIAL,
    SEQ_STORE
  } prm_seq_type;

endpackage

//--- tb/power_rx_monitor_scan_protect_gpio_bench.sv
// Self-checking bench for the receiver monitor block
`timescale 1ns/10ps
`default_nettype none

module power_rx_monitor_scan_protect_gpio_bench;
  logic ref_clk, rst, regWr, regRd, rdSeen, adcCmp, irqLine;
  logic ntcHot, ntcCold, dcInOk, bodLow, buckGood;
  logic [1:0] dieHot, dieCool;
  logic [3:0] pinExt, pinLevel, pinOut, pinOe;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [83:0] chanVal;
  logic [31:0] rnd;
  logic [7:0] expQ[$];
  logic [7:0] rAddr[9];
  logic [7:0] rVal[9];
  logic [11:0] v;
  logic [2:0] adcChanSel;
  logic [11:0] adcTrial;
  logic adcSample, buckEnable, ldoEnable, ldoDischarge, ldoFeedFromBuck;
  logic irqOut, irqOe;
  prm_pkg::prm_sense_type senseIn;
  int seed, bad_count, check_count;

  assign senseIn = {adcCmp, dieHot, dieCool, ntcHot, ntcCold, dcInOk, bodLow, buckGood,
                    pinLevel};

  prm_monitor #(.LDO_DELAY(20)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .senseIn(senseIn),
    .adcChanSel(adcChanSel), .adcSample(adcSample), .adcTrial(adcTrial),
    .buckEnable(buckEnable), .ldoEnable(ldoEnable), .ldoDischarge(ldoDischarge),
    .ldoFeedFromBuck(ldoFeedFromBuck), .pinOut(pinOut), .pinOe(pinOe),
    .irqOut(irqOut), .irqOe(irqOe));

  prm_afe_model u_afe (
    .adcChanSel(adcChanSel), .adcTrial(adcTrial), .chanVal(chanVal), .adcCmp(adcCmp),
    .pinOe(pinOe), .pinExt(pinExt), .irqOe(irqOe), .pinLevel(pinLevel),
    .irqLine(irqLine));

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdSeen) chk({4'h0, regRdata}, {4'h0, expQ.pop_front()});
    rdSeen <= regRd;
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard
  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    {rst, regWr, regRd, ntcHot, ntcCold, dcInOk, bodLow, buckGood} = 8'h80;
    {dieHot, dieCool, pinExt, regAddr, regWdata} = '0;
    seed = 2;
    bad_count = 0;
    check_count = 0;
    for (int c = 0; c < 7; c++) begin
      rnd = $random(seed);
      chanVal[c*12 +: 12] = rnd[11:0];
    end
    rAddr = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h00, 8'h01, 8'h02, 8'h1F};
    rVal = '{prm_pkg::RST_IRQ_EN, prm_pkg::RST_SYS_LOW, prm_pkg::RST_SYS_HIGH,
             prm_pkg::RST_PIN_CTRL, prm_pkg::RST_CHAN_EN, 8'h00, 8'h00, 8'h00, 8'h00};
    wt(6);
    rst <= 1'b0;
    wt(1);
    for (int i = 0; i < 9; i++) rd(rAddr[i], rVal[i]);
    // Pins: all buffers on, alternate pull-downs, random outside level
    rnd = $random(seed);
    pinExt <= rnd[3:0];
    wr(8'h07, 8'hF5);
    wt(4);
    chk({8'h00, pinOe}, 12'h00A);
    rd(8'h08, {4'h0, pinExt & 4'h5});
    // Only pins 0 and 1 keep their input buffers
    wr(8'h07, 8'h35);
    wt(4);
    rd(8'h08, {4'h0, pinExt & 4'h1});
    // Scan of six channels; whole pass fits well inside one slow byte
    wr(8'h09, 8'hFD);
    wt(6 * 113 + 40);
    rd(8'h09, 8'h7D);
    for (int c = 0; c < 7; c++) begin
      v = (c == 1) ? 12'h000 : chanVal[c*12 +: 12];
      rd(8'h0B + 8'(c), v[11:4]);
      rd(8'h12 + 8'(c), {4'h0, v[3:0]});
    end
    // Die sensor a with thermal cutoff armed
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h01);
    wr(8'h06, 8'hF5);
    wt(2);
    chk({11'h0, buckEnable}, 12'h001);
    dieHot[0] <= 1'b1;
    wt(8);
    chk({11'h0, irqOe}, 12'h001);
    chk({11'h0, buckEnable}, 12'h000);
    rd(8'h06, 8'hF4);
    dieHot[0] <= 1'b0;
    dieCool[0] <= 1'b1;
    wt(8);
    rd(8'h00, 8'h0A);
    wr(8'h02, 8'h0A);
    wt(3);
    chk({11'h0, irqLine}, 12'h001);
    rd(8'h00, 8'h00);
    dieCool[0] <= 1'b0;
    // Sensor b without cutoff, cleared by reading
    wr(8'h05, 8'h80);
    wr(8'h06, 8'hF5);
    dieHot[1] <= 1'b1;
    wt(8);
    chk({11'h0, buckEnable}, 12'h001);
    chk({11'h0, irqOe}, 12'h001);
    rd(8'h00, 8'h04);
    rd(8'h00, 8'h00);
    wt(2);
    chk({11'h0, irqOe}, 12'h000);
    dieHot[1] <= 1'b0;
    // Thermistor window, gating and cutoff
    wr(8'h04, 8'h00);
    ntcHot <= 1'b1;
    wt(8);
    rd(8'h00, 8'h20);
    chk({11'h0, irqOe}, 12'h000);
    wr(8'h04, 8'h04);
    wt(3);
    chk({11'h0, irqOe}, 12'h001);
    wr(8'h05, 8'h08);
    wt(3);
    chk({11'h0, buckEnable}, 12'h000);
    ntcHot <= 1'b0;
    ntcCold <= 1'b1;
    wr(8'h02, 8'h20);
    wt(8);
    rd(8'h00, 8'h40);
    chk({11'h0, irqOe}, 12'h000);
    // Soft reset returns control bytes and flags to reset values
    wr(8'h06, 8'h02);
    rd(8'h05, prm_pkg::RST_SYS_LOW);
    rd(8'h06, prm_pkg::RST_SYS_HIGH);
    rd(8'h00, 8'h00);
    // Regulator start, feed switch and brown-out
    dcInOk <= 1'b1;
    wt(10);
    chk({10'h0, ldoEnable, ldoDischarge}, 12'h001);
    wt(20);
    chk({10'h0, ldoEnable, ldoDischarge}, 12'h002);
    buckGood <= 1'b1;
    wt(6);
    chk({11'h0, ldoFeedFromBuck}, 12'h001);
    bodLow <= 1'b1;
    wt(6);
    chk({10'h0, ldoEnable, ldoDischarge}, 12'h001);
    wt(2);
    conclude();
  end
endmodule

`default_nettype wire

//--- tb/prm_afe_model.sv
// Converter comparator and open-drain wiring that face the monitor block
`timescale 1ns/10ps
`default_nettype none

module prm_afe_model (
  // Converter side
  input  wire logic [2:0]  adcChanSel,
  input  wire logic [11:0] adcTrial,
  input  wire logic [83:0] chanVal,
  output logic             adcCmp,
  // Pin side
  input  wire logic [3:0]  pinOe,
  input  wire logic [3:0]  pinExt,
  input  wire logic        irqOe,
  output logic      [3:0]  pinLevel,
  output logic             irqLine
);
  // Compare input against trial code; unused mux code reads full scale
  always_comb begin
    if (adcChanSel < 3'h7) begin
      adcCmp = chanVal[adcChanSel*12 +: 12] >= adcTrial;
    end else begin
      adcCmp = 1'b1;
    end
  end

  // Pulled low when driven, else the external level, always defined
  assign pinLevel = pinExt & ~pinOe;
  // Pull-up on the interrupt line
  assign irqLine  = ~irqOe;
endmodule

`default_nettype wire

//--- tb/prm_monitor_asserts.sv
// Port-level checks for the receiver monitor block
`timescale 1ns/10ps
`default_nettype none

module prm_monitor_asserts #(
  parameter int LDO_DELAY = 20
) (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // Register port
  input wire logic [7:0]             regAddr,
  input wire logic [7:0]             regWdata,
  input wire logic                   regWr,
  // Sensing and outputs
  input wire prm_pkg::prm_sense_type senseIn,
  input wire logic                   adcSample,
  input wire logic [2:0]             adcChanSel,
  input wire logic [11:0]            adcTrial,
  input wire logic                   ldoEnable,
  input wire logic                   ldoDischarge,
  input wire logic                   ldoFeedFromBuck,
  input wire logic [3:0]             pinOut,
  input wire logic [3:0]             pinOe,
  input wire logic                   irqOut,
  input wire logic                   irqOe
);
  logic [3:0] drvShadow_q;
  logic [7:0] okCnt_q;
  logic [7:0] selShadow_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Last drive bits written by software
  always_ff @(posedge ref_clk) begin
    if (rst) drvShadow_q <= 4'hF;
    else if (regWr && regAddr == 8'h07) drvShadow_q <= regWdata[3:0];
  end

  // Last channel selects written; top bit stands for the unused mux code
  always_ff @(posedge ref_clk) begin
    if (rst) selShadow_q <= 8'h7F;
    else if (regWr && regAddr == 8'h09) selShadow_q <= {1'b0, regWdata[6:0]};
  end

  // Raw input-ok run length; saturates so a long run cannot wrap
  always_ff @(posedge ref_clk) begin
    if (rst || !senseIn.dcInOk || senseIn.bodLow) okCnt_q <= 8'h00;
    else if (okCnt_q != 8'hFF) okCnt_q <= okCnt_q + 8'h01;
  end

  chk_pin_drive: assert property (
    regWr && regAddr == 8'h07 |-> ##2 pinOe == ~drvShadow_q)
    else $error("pin pull-down does not follow drive bits");
  chk_od_low: assert property (
    pinOut == 4'h0 && irqOut == 1'b0)
    else $error("open-drain data not low");
  chk_die_irq: assert property (
    $rose(|{senseIn.dieHot, senseIn.dieCool}) |-> ##[3:7] irqOe)
    else $error("die event did not pull interrupt");
  chk_ldo_delay: assert property (
    $rose(ldoEnable) |-> okCnt_q >= LDO_DELAY && okCnt_q <= LDO_DELAY + 8)
    else $error("regulator start delay wrong");
  chk_ldo_brown: assert property (
    senseIn.bodLow [*6] |-> !ldoEnable)
    else $error("regulators on during brown-out");
  chk_dis_pair: assert property (
    ldoDischarge == !ldoEnable)
    else $error("discharge not opposite to enable");
  chk_feed_follow: assert property (
    $stable(senseIn.buckGood) [*5] |-> ldoFeedFromBuck == senseIn.buckGood)
    else $error("regulator feed not following buck good");
  chk_scan_start: assert property (
    regWr && regAddr == 8'h09 && regWdata[7] && regWdata[6:0] != 7'h00
    |=> adcSample [*8])
    else $error("scan start did not sample");
  chk_sel_only: assert property (
    adcSample |-> selShadow_q[adcChanSel])
    else $error("unselected channel sampled");
  chk_trial_msb: assert property (
    $fell(adcSample) |-> adcTrial == 12'h800)
    else $error("first trial is not the top bit");
endmodule

bind prm_monitor prm_monitor_asserts #(.LDO_DELAY(LDO_DELAY)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .senseIn(senseIn), .adcSample(adcSample), .adcChanSel(adcChanSel),
  .adcTrial(adcTrial),
  .ldoEnable(ldoEnable), .ldoDischarge(ldoDischarge),
  .ldoFeedFromBuck(ldoFeedFromBuck), .pinOut(pinOut), .pinOe(pinOe),
  .irqOut(irqOut), .irqOe(irqOe)
);

`default_nettype wire
